// ==== rtl/pdm_pkg.sv ====
// Shared constants and types for the program and data memory block.
// Assumes one 20 MHz clock and a synchronous active-high reset at both ends.
package pdm_pkg;
   localparam int PDM_PW = 16;
   localparam int PDM_PA = 11;
   localparam int PDM_DW = 8;
   localparam logic [10:0] PDM_RESET_VEC = 11'h000;
   localparam logic [7:0] PDM_SFR_LAST = 8'h7F;
   localparam logic [7:0] PDM_GPR_FIRST = 8'h80;
   localparam logic [7:0] PDM_GPR_LAST = 8'hDF;
   localparam logic [7:0] PDM_EEC_ADDR = 8'h40;
   localparam logic [7:0] PDM_ZERO = 8'h00;
   localparam logic [7:0] PDM_BP_ADDR = 8'h04;
   localparam logic [7:0] PDM_TBLP_ADDR = 8'h07;
   localparam logic [7:0] PDM_TBHP_ADDR = 8'h08;
   localparam logic [7:0] PDM_TBH_ADDR = 8'h09;
   localparam logic [7:0] PDM_RO_ADDR = 8'h0A;
   localparam int PDM_BANK_BIT = 0;
   localparam int PDM_TBHP_BITS = 3;
   // Data memory operation codes issued by the core.
   typedef enum logic [2:0] {
      PDM_OP_NONE, PDM_OP_RD, PDM_OP_WR, PDM_OP_BSET, PDM_OP_BCLR, PDM_OP_TABRD
   } pdm_op_t;
endpackage

// ==== rtl/pdm_if.sv ====
// Interface joining the memory block and the core's fetch and execute logic.
// Assumes both ends share ref_clk; pin wires are resolved by the bench from the enables.
`timescale 1ns/1ps
interface pdm_if (input wire logic ref_clk, input wire logic sys_rst);
   import pdm_pkg::*;
   logic [10:0] fetch_addr;
   logic fetch_en;
   logic [15:0] fetch_word;
   logic fetch_stall;
   pdm_op_t op;
   logic indirect;
   logic [7:0] addr;
   logic [2:0] bit_sel;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic busy;
   logic prog_serial_data_pin_i;
   logic prog_serial_data_pin_o;
   logic prog_serial_data_pin_oe;
   logic prog_serial_clock_pin;
   logic debug_mode;
   modport mem (input ref_clk, sys_rst, fetch_addr, fetch_en, op, indirect, addr, bit_sel, wdata,
      prog_serial_data_pin_i, prog_serial_clock_pin, debug_mode,
      output fetch_word, fetch_stall, rdata, busy, prog_serial_data_pin_o, prog_serial_data_pin_oe);
   modport core (input ref_clk, sys_rst, fetch_word, fetch_stall, rdata, busy,
      output fetch_addr, fetch_en, op, indirect, addr, bit_sel, wdata);
endinterface

// ==== rtl/pdm_mem.sv ====
// Program store, table-read path and two-bank data memory of the core.
// Assumes the core issues one data operation at a time and waits while busy is high.
//
// Operation
// RQ1 - Program store of 2K sixteen-bit words.
// RQ2 - Execution starts at address zero after reset.
// RQ3 - Table address from both table pointer registers.
// RQ4 - Table read writes low byte to operand; only general-byte operands (80H to DFH) are written.
// RQ5 - Table read loads high byte, missing bits zero.
// RQ6 - Table instructions take two instruction cycles.
// RQ7 - Table high byte ignores software writes.
// RQ8 - Software masks interrupts around main table reads.
// RQ9 - Data memory is byte-wide RAM from zero.
// RQ10 - Bank 0 special registers; bank 1 control only.
// RQ11 - Ninety-six general bytes at 80H to DFH.
// RQ12 - Bank pointer selects the data bank.
// RQ13 - Bit set and clear change one bit.
// RQ14 - Some special registers are write protected.
// RQ15 - Programming uses one two-way data pin; this end never drives it, oe is tied low.
// RQ16 - Nothing else drives the programming pins.
// RQ17 - Debug offers two-way data, input clock; this end never drives the data pin.
// RQ18 - Shared debug pins keep programming duty only.
// RQ19 - Direct addressing always reaches bank 0.
// RQ20 - Bank select bit resets to zero.
// RQ21 - Unused special addresses read as zero.
// RQ22 - Eleven table bits from low and high pointers.
// RQ23 - Table read borrows fetch port one cycle.
`timescale 1ns/1ps
module pdm_mem import pdm_pkg::*; #(
   parameter int GPR_DEPTH = 96,
   parameter logic [15:0] INIT_WORD = 16'h0000
) (
   // Memory side of the core link.
   pdm_if.mem bus
);
   // ==========================================================
   // Storage and control registers
   // ==========================================================
   // Bit positions of the three sampled pins inside the synchroniser vectors.
   localparam int PIN_DATA = 0;
   localparam int PIN_CLK = 1;
   localparam int PIN_DEBUG = 2;
   localparam int PIN_N = 3;
   // The store is preset from INIT_WORD; a loader may rewrite words through the hierarchy.
   logic [PDM_PW-1:0] prog_mem [0:(1<<PDM_PA)-1]; // RQ1
   // General bytes are volatile and come out of reset unchanged.
   logic [PDM_DW-1:0] gpr [0:GPR_DEPTH-1]; // RQ9
   logic [7:0] table_ptr_lo;
   logic [7:0] table_ptr_hi;
   logic [7:0] table_high_byte;
   logic [7:0] eeprom_control_reg;
   logic [7:0] ro_status;
   logic bank_select_bit;
   logic tab_phase;
   logic [7:0] tab_dest;
   logic [7:0] rdata_q;
   logic [7:0] sfr_val;
   logic [PIN_N-1:0] pin_sync1;
   logic [PIN_N-1:0] pin_sync2;

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   // The general area is a fixed window of the map, so its depth is not free to choose.
   if (GPR_DEPTH != int'(PDM_GPR_LAST) - int'(PDM_GPR_FIRST) + 1) begin : g_bad_depth
      $error("pdm_mem: GPR_DEPTH must equal the size of the general area");
   end
   // The table high byte takes what lies above the low byte, and holds at most one byte of it.
   if (PDM_PW <= PDM_DW || PDM_PW > 2 * PDM_DW) begin : g_bad_word
      $error("pdm_mem: program word must be longer than one byte and at most two");
   end
   // The table address is a full low pointer plus a few bits of the high pointer.
   if (PDM_PA != PDM_DW + PDM_TBHP_BITS) begin : g_bad_addr
      $error("pdm_mem: table address width does not match the pointers");
   end

   // ==========================================================
   // Decoding
   // ==========================================================
   wire logic [10:0] table_addr = {table_ptr_hi[PDM_TBHP_BITS-1:0], table_ptr_lo}; // RQ3 RQ22
   // Direct addressing never reaches bank 1, whatever the bank bit holds.
   wire logic bank1 = bus.indirect && bank_select_bit; // RQ12 RQ19
   wire logic is_gpr = !bank1 && bus.addr >= PDM_GPR_FIRST && bus.addr <= PDM_GPR_LAST; // RQ11
   wire logic is_eec = bank1 && bus.addr == PDM_EEC_ADDR; // RQ10
   // Special register selects; all of them live in bank 0.
   wire logic sel_bp = !bank1 && bus.addr == PDM_BP_ADDR;
   wire logic sel_tblp = !bank1 && bus.addr == PDM_TBLP_ADDR;
   wire logic sel_tbhp = !bank1 && bus.addr == PDM_TBHP_ADDR;
   wire logic [6:0] gidx = 7'(bus.addr - PDM_GPR_FIRST);
   wire logic [6:0] tidx = 7'(tab_dest - PDM_GPR_FIRST);
   wire logic tab_to_gpr = tab_dest >= PDM_GPR_FIRST && tab_dest <= PDM_GPR_LAST;
   wire logic [7:0] bit_mask = 8'h01 << bus.bit_sel;
   wire logic is_write = bus.op == PDM_OP_WR || bus.op == PDM_OP_BSET || bus.op == PDM_OP_BCLR;
   wire logic wr_sfr = is_write && !is_gpr;
   // A table read starts when the core names one and none is already under way.
   wire logic tab_start = bus.op == PDM_OP_TABRD && !tab_phase; // RQ6
   // Emulation mode silences the general pin function, while the pins stay programming pins.
   wire logic pins_shown = !pin_sync2[PIN_DEBUG];
   wire logic [7:0] status_now = pins_shown ? {6'h00, pin_sync2[PIN_CLK], pin_sync2[PIN_DATA]} : PDM_ZERO; // RQ18

   // Read value of the addressed location; unused special addresses give zero.
   function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic b1);
      logic [7:0] v;
      v = PDM_ZERO; // RQ21
      if (b1) begin
         if (a == PDM_EEC_ADDR) v = eeprom_control_reg;
      end else if (a == PDM_BP_ADDR) begin
         v = {7'h00, bank_select_bit};
      end else if (a == PDM_TBLP_ADDR) begin
         v = table_ptr_lo;
      end else if (a == PDM_TBHP_ADDR) begin
         v = table_ptr_hi;
      end else if (a == PDM_TBH_ADDR) begin
         v = table_high_byte;
      end else if (a == PDM_RO_ADDR) begin
         v = ro_status;
      end
      return v;
   endfunction

   // Called from a process, so a change of any register read inside the function is seen at once.
   always_comb begin
      sfr_val = sfr_read(bus.addr, bank1);
   end
   wire logic [7:0] cur_val = is_gpr ? gpr[gidx] : sfr_val;
   wire logic [7:0] next_val = bus.op == PDM_OP_BSET ? (cur_val | bit_mask) :
      bus.op == PDM_OP_BCLR ? (cur_val & ~bit_mask) : bus.wdata; // RQ13

   // ==========================================================
   // Link outputs
   // ==========================================================
   // Fetch port is lent to the table read in its second cycle.
   assign bus.fetch_stall = tab_phase; // RQ23
   // Busy covers both cycles, so the core cannot slip a second request in between.
   assign bus.busy = tab_start || tab_phase; // RQ6
   // Read data stands until the next read replaces it.
   assign bus.rdata = rdata_q;
   // This end only listens on the programming pins; the programmer owns both of them.
   assign bus.prog_serial_data_pin_o = 1'b0; // RQ15 RQ17 RQ18
   assign bus.prog_serial_data_pin_oe = 1'b0;

   // ==========================================================
   // Program store port
   // ==========================================================
   // Every word starts as INIT_WORD, so an unloaded store reads back a known value.
   initial begin
      for (int i = 0; i < (1 << PDM_PA); i++) prog_mem[i] = INIT_WORD;
   end

   // Table read holds the port in its second cycle, so the core keeps its next fetch address.
   always_ff @(posedge bus.ref_clk) begin
      if (tab_phase) begin
         bus.fetch_word <= prog_mem[table_addr]; // RQ23
      end else if (bus.fetch_en) begin
         bus.fetch_word <= prog_mem[bus.fetch_addr];
      end
   end

   // ==========================================================
   // Data memory and registers
   // ==========================================================
   // Core writes and the table's low byte never meet, since the core waits out the table read.
   always_ff @(posedge bus.ref_clk) begin
      if (is_write && is_gpr) gpr[gidx] <= next_val; // RQ11 RQ13
      if (tab_phase && tab_to_gpr) gpr[tidx] <= prog_mem[table_addr][7:0]; // RQ4
   end

   // Special registers; the table high byte and status byte are write protected.
   always_ff @(posedge bus.ref_clk) begin
      if (bus.sys_rst) begin
         bank_select_bit <= 1'b0; // RQ20
         table_ptr_lo <= PDM_ZERO;
         table_ptr_hi <= PDM_ZERO;
         table_high_byte <= PDM_ZERO;
         eeprom_control_reg <= PDM_ZERO;
         tab_phase <= 1'b0;
         tab_dest <= PDM_ZERO;
         rdata_q <= PDM_ZERO;
         ro_status <= PDM_ZERO;
      end else begin
         ro_status <= status_now;
         tab_phase <= tab_start; // RQ6
         if (tab_start) tab_dest <= bus.addr;
         if (tab_phase) begin
            // Sixteen-bit words fill the byte; narrower fields would zero-extend.
            table_high_byte <= 8'(prog_mem[table_addr][PDM_PW-1:8]); // RQ5
         end
         if (bus.op == PDM_OP_RD) rdata_q <= cur_val;
         if (wr_sfr) begin
            if (is_eec) eeprom_control_reg <= next_val; // RQ10
            else if (sel_bp) bank_select_bit <= next_val[PDM_BANK_BIT];
            else if (sel_tblp) table_ptr_lo <= next_val;
            else if (sel_tbhp) table_ptr_hi <= next_val;
            // Writes to the table high byte and status fall through unchanged.
         end // RQ7 RQ14
      end
   end

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Pins are asynchronous to ref_clk; only the second stage is read by logic.
   wire logic [PIN_N-1:0] pin_raw = {bus.debug_mode, bus.prog_serial_clock_pin, bus.prog_serial_data_pin_i};
   always_ff @(posedge bus.ref_clk) begin
      pin_sync1 <= pin_raw;
      pin_sync2 <= pin_sync1;
   end
endmodule

// ==== rtl/pdm_core.sv ====
// Core end: program counter fetch and a user-side data operation port.
// Assumes the memory end answers busy and fetch_stall as it documents.
`timescale 1ns/1ps
module pdm_core import pdm_pkg::*; (
   // Core link.
   pdm_if.core bus,
   // User-side operation request.
   input wire logic req_valid,
   input wire pdm_op_t req_op,
   input wire logic req_indirect,
   input wire logic [7:0] req_addr,
   input wire logic [2:0] req_bit,
   input wire logic [7:0] req_wdata,
   output logic req_ready,
   output logic [15:0] instr,
   output logic [10:0] pc,
   output logic [7:0] rd_data
);
   typedef enum {PDM_S_RUN, PDM_S_WAIT} pdm_state_t;
   pdm_state_t state;
   wire logic issue = req_valid && state == PDM_S_RUN;

   assign bus.fetch_addr = pc;
   assign bus.fetch_en = !bus.fetch_stall;
   assign bus.op = issue ? req_op : PDM_OP_NONE;
   assign bus.indirect = req_indirect;
   assign bus.addr = req_addr;
   assign bus.bit_sel = req_bit;
   assign bus.wdata = req_wdata;
   assign req_ready = state == PDM_S_RUN;
   assign instr = bus.fetch_word;
   assign rd_data = bus.rdata;

   // Counter holds while the table read borrows the port.
   always_ff @(posedge bus.ref_clk) begin
      if (bus.sys_rst) begin
         pc <= PDM_RESET_VEC; // RQ2
         state <= PDM_S_RUN;
      end else begin
         if (!bus.fetch_stall) pc <= 11'(pc + 11'h001);
         case (state)
            PDM_S_RUN: if (issue && req_op == PDM_OP_TABRD) state <= PDM_S_WAIT;
            PDM_S_WAIT: state <= PDM_S_RUN;
            default: state <= PDM_S_RUN;
         endcase
      end
   end
endmodule

// ==== tb/pdm_chk.sv ====
// Concurrent checks on the link between the memory end and the core end.
// Assumes it sits beside the interface, every input connected by name.
`timescale 1ns/1ps
module pdm_chk import pdm_pkg::*; #(
   parameter logic [15:0] INIT_WORD = 16'h0000
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Link signals.
   input wire logic [10:0] fetch_addr,
   input wire logic fetch_en,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_stall,
   input wire pdm_op_t op,
   input wire logic indirect,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic busy,
   input wire logic prog_serial_data_pin_oe
);
   // ==========================================
   // Properties
   // One clock domain, so clocking and disable are stated once.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // A direct read is only taken while the table path is idle.
   wire rd_dir = op == PDM_OP_RD && !indirect && !busy;
   a_reset_vec_pc: assert property ($fell(sys_rst) |-> fetch_addr == PDM_RESET_VEC)
      else $error("pc not at reset vector");
   a_table_two_cycles: assert property (op == PDM_OP_TABRD && !fetch_stall |-> busy ##1 (busy && fetch_stall)
      ##1 !fetch_stall) else $error("table read not two cycles");
   a_fetch_word_ok: assert property (fetch_en |=> fetch_word == INIT_WORD)
      else $error("fetched word wrong");
   a_unused_read_zero: assert property (rd_dir && addr > PDM_GPR_LAST |=> rdata == PDM_ZERO)
      else $error("unused address not zero");
   a_bank_upper_zero: assert property (rd_dir && addr == PDM_BP_ADDR |=> rdata[7:1] == 7'h00)
      else $error("bank pointer upper bits set");
   a_direct_bank_zero: assert property (rd_dir && addr == PDM_EEC_ADDR |=> rdata == PDM_ZERO)
      else $error("direct access reached bank 1");
   a_gpr_read_back: assert property (op == PDM_OP_WR && !indirect && !busy && addr >= PDM_GPR_FIRST
      && addr <= PDM_GPR_LAST ##1 rd_dir && addr == $past(addr) |=> rdata == $past(wdata, 2))
      else $error("general byte lost");
   a_pin_released: assert property (!prog_serial_data_pin_oe)
      else $error("programming pin driven");
   a_pc_holds_stall: assert property (fetch_stall |=> fetch_addr == $past(fetch_addr))
      else $error("fetch address moved during table read");
endmodule

// ==== tb/pdm_tb.sv ====
// Bench joining the memory end and the core end over the link.
// Assumes the store is preset to one word, so table data is known.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module pdm_tb import pdm_pkg::*; ();
   localparam logic [15:0] INIT_WORD = 16'hA55A;
   // Word placed at the address that the table scenario points to.
   localparam logic [15:0] TAB_WORD = 16'h0F1A;
   logic debug_mode = 1'b0;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   pdm_op_t req_op = PDM_OP_NONE;
   logic req_indirect = 1'b0;
   logic [7:0] req_addr = 8'h00;
   logic [2:0] req_bit = 3'h0;
   logic [7:0] req_wdata = 8'h00;
   logic req_ready;
   logic [15:0] instr;
   logic [10:0] pc;
   logic [7:0] rd_data;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   pdm_if pif (.ref_clk(ref_clk), .sys_rst(sys_rst));
   // The released data pin rests at its pull-up level.
   assign pif.prog_serial_data_pin_i = pif.prog_serial_data_pin_oe ? pif.prog_serial_data_pin_o : 1'b1;
   assign pif.prog_serial_clock_pin = 1'b0;
   assign pif.debug_mode = debug_mode;
   pdm_mem #(.INIT_WORD(INIT_WORD)) pdm_mem_inst (.bus(pif.mem));
   pdm_core pdm_core_inst (.bus(pif.core), .req_valid(req_valid), .req_op(req_op), .req_indirect(req_indirect),
      .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata), .req_ready(req_ready), .instr(instr),
      .pc(pc), .rd_data(rd_data));
   pdm_chk #(.INIT_WORD(INIT_WORD)) pdm_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .fetch_addr(pif.fetch_addr), .fetch_en(pif.fetch_en), .fetch_word(pif.fetch_word),
      .fetch_stall(pif.fetch_stall), .op(pif.op), .indirect(pif.indirect), .addr(pif.addr), .wdata(pif.wdata),
      .rdata(pif.rdata), .busy(pif.busy), .prog_serial_data_pin_oe(pif.prog_serial_data_pin_oe));
   // ==========================================
   // Clock, timeout and verdict
   initial forever #25 ref_clk = ~ref_clk;
   // A hung handshake would stall the run, so cycles are capped.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 1000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // Requests: held from a falling edge until taken with ready high.
   task automatic issue(input pdm_op_t o, input logic ind, input logic [7:0] a, d, input logic [2:0] b);
      int k;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_op = o;
      req_indirect = ind;
      req_addr = a;
      req_wdata = d;
      req_bit = b;
      for (k = 0; k < 8 && req_ready !== 1'b1; k++) begin
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
   endtask
   task automatic expect_rd(input logic ind, input logic [7:0] a, ex, input string nm);
      issue(PDM_OP_RD, ind, a, 8'h00, 3'h0);
      @(negedge ref_clk);
      @(negedge ref_clk);
      `CHK(nm, ex, rd_data)
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      `CHK("pc", PDM_RESET_VEC, pc)
      expect_rd(1'b0, PDM_BP_ADDR, PDM_ZERO, "bank");
      expect_rd(1'b0, PDM_TBH_ADDR, PDM_ZERO, "tbh");
      `CHK("instr", INIT_WORD, instr)
   endtask
   task automatic t_gpr();
      issue(PDM_OP_WR, 1'b0, PDM_GPR_FIRST, 8'h3C, 3'h0);
      expect_rd(1'b0, PDM_GPR_FIRST, 8'h3C, "gpr_lo");
      issue(PDM_OP_WR, 1'b0, PDM_GPR_LAST, 8'hC3, 3'h0);
      issue(PDM_OP_BSET, 1'b0, PDM_GPR_LAST, 8'h00, 3'h2);
      issue(PDM_OP_BCLR, 1'b0, PDM_GPR_LAST, 8'h00, 3'h7);
      expect_rd(1'b0, PDM_GPR_LAST, 8'h47, "bits");
      issue(PDM_OP_WR, 1'b0, 8'hE0, 8'hFF, 3'h0);
      expect_rd(1'b0, 8'hE0, PDM_ZERO, "unused");
   endtask
   task automatic t_table();
      // A word unlike the preset at the pointed address shows that both pointers form the address.
      pdm_mem_inst.prog_mem[11'h7FF] = TAB_WORD;
      issue(PDM_OP_WR, 1'b0, PDM_TBLP_ADDR, 8'hFF, 3'h0);
      // Only the low three bits of the high pointer may reach the address.
      issue(PDM_OP_WR, 1'b0, PDM_TBHP_ADDR, 8'hF7, 3'h0);
      // No interrupt source runs here, so nothing can overwrite the table high byte.
      issue(PDM_OP_TABRD, 1'b0, 8'h90, 8'h00, 3'h0);
      expect_rd(1'b0, 8'h90, TAB_WORD[7:0], "tab_lo");
      expect_rd(1'b0, PDM_TBH_ADDR, TAB_WORD[15:8], "tab_hi");
      issue(PDM_OP_WR, 1'b0, PDM_TBH_ADDR, 8'h00, 3'h0);
      expect_rd(1'b0, PDM_TBH_ADDR, TAB_WORD[15:8], "tbh_ro");
      expect_rd(1'b0, PDM_TBHP_ADDR, 8'hF7, "tbhp");
   endtask
   task automatic t_bank();
      issue(PDM_OP_WR, 1'b0, PDM_BP_ADDR, 8'h01, 3'h0);
      expect_rd(1'b0, PDM_BP_ADDR, 8'h01, "bp");
      issue(PDM_OP_WR, 1'b0, 8'hA0, 8'h5A, 3'h0);
      expect_rd(1'b0, 8'hA0, 8'h5A, "direct");
      expect_rd(1'b1, 8'hA0, PDM_ZERO, "bank1");
      issue(PDM_OP_WR, 1'b1, PDM_EEC_ADDR, 8'hC5, 3'h0);
      expect_rd(1'b1, PDM_EEC_ADDR, 8'hC5, "eec1");
      expect_rd(1'b0, PDM_EEC_ADDR, PDM_ZERO, "eec0");
      issue(PDM_OP_WR, 1'b0, PDM_BP_ADDR, 8'h00, 3'h0);
      expect_rd(1'b1, 8'hA0, 8'h5A, "bank0");
   endtask
   // Pin status follows the pulled-up data pin, ignores writes, and goes quiet in emulation mode.
   task automatic t_pins();
      expect_rd(1'b0, PDM_RO_ADDR, 8'h01, "pins");
      issue(PDM_OP_WR, 1'b0, PDM_RO_ADDR, 8'hFE, 3'h0);
      expect_rd(1'b0, PDM_RO_ADDR, 8'h01, "ro");
      @(negedge ref_clk);
      debug_mode = 1'b1;
      repeat (3) @(negedge ref_clk);
      expect_rd(1'b0, PDM_RO_ADDR, PDM_ZERO, "debug");
   endtask
   // Reset is released on a falling edge after twelve cycles.
   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_reset();
      t_gpr();
      t_table();
      t_bank();
      t_pins();
      @(negedge ref_clk);
      req_valid = 1'b0;
      report_and_stop();
   end
endmodule
